/* hsi_rx_irq_status.v */
// Two-channel receive error handling, status registers and shared interrupt.
//
// Added by the designer: the APB register port and the address map.
`include "hsi_defines.vh"
`default_nettype none

// Overview of operation
// R1 - Info frame: CRC/abort gives message end; bad N(S) answers; bad N(R) protocol error.
// R2 - Supervisory frame: CRC/abort silent; bad N(R) or info field gives protocol error.
// R3 - Any listed frame error leaves send and receive state variables unchanged.
// R4 - Every register seen by the CPU is eight bits wide.
// R5 - Each channel has its own identical, fully independent register file; here channel B's primary bits 2..1 show channel A status.
// R6 - Reset selects interrupt transfer; DMA only when the DMA select bit is set.
// R7 - Each channel picks interrupt or DMA mode independently.
// R8 - One shared active-low interrupt output serves both channels.
// R9 - Five primary and six extended indications per channel; here only two primary and three extended indications are raised.
// R10 - Channel B primary bits 2..0 point to A primary, A extended, B extended.
// R11 - Channel B primary bits 7..3 hold channel B's own sources.
// R12 - The CPU reads channel B primary status first on each interrupt.
// R13 - Interrupt stays active until all sources are cleared by reading status.
// R14 - Masking all then restoring the mask drops and re-raises the interrupt.
// R15 - Each primary status indication can be masked individually.
// R16 - Interrupt mode: pool full when 32 bytes of an open message are held.
// R17 - Interrupt mode: message end when a whole message or its tail is buffered.
// R18 - DMA mode: message end only after DMA has read out the whole message; here a CRC/abort info frame also raises it at frame end.
// R19 - Frame overflow when buffer is full and a new frame starts.
// R20 - Frame start is raised only with its enable bit set.
// R21 - Frame start after address match, or two bytes after the flag in transparent mode.
// R22 - Header, first address and status bits 3..0 are valid at frame start.
// R23 - Masked indications are still recorded but do not drive the interrupt.
module hsi_rx_irq_status (
   input wire clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`HSI_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg int_n,
   input wire [1:0] rx_frame_begin,
   input wire [1:0] rx_byte_strobe,
   input wire [1:0] rx_addr_match,
   input wire [11:0] rx_buf_count,
   input wire [1:0] rx_buf_full,
   input wire [1:0] rx_msg_done,
   input wire [1:0] rx_dma_read_done,
   input wire [1:0] rx_frame_done,
   input wire [1:0] rx_frame_is_info,
   input wire [1:0] rx_frame_is_super,
   input wire [1:0] rx_crc_err,
   input wire [1:0] rx_aborted,
   input wire [1:0] rx_ns_err,
   input wire [1:0] rx_nr_err,
   input wire [1:0] rx_has_ifield,
   input wire [15:0] rx_header_in,
   input wire [15:0] rx_address_in,
   input wire [7:0] rx_status_in,
   output reg [1:0] s_response_req,
   output reg [1:0] state_advance,
   output reg [1:0] dma_mode
);

   localparam ST_IDLE = 3'b001;
   localparam ST_FETCH = 3'b010;
   localparam ST_DONE = 3'b100;

   // Set wins over clear, so an event landing on the clearing read survives.
   function [7:0] hsi_upd;
      input [7:0] cur;
      input [7:0] set;
      input [7:0] clr;
      begin
         hsi_upd = (cur & ~clr) | set;
      end
   endfunction

   reg [2:0] st_r;
   reg [7:0] snap_r;
   reg [7:0] rd_nxt;
   reg err_nxt;

   wire [15:0] prim_w;
   wire [15:0] ext_w;
   wire [15:0] mask_w;
   wire [15:0] sub_rd_w;
   wire [1:0] dma_w;
   wire [1:0] fs_en_w;
   wire [1:0] recog_w;
   wire [1:0] cap_w;
   wire [1:0] crc_set_w;
   wire [1:0] abort_set_w;
   wire [1:0] sresp_w;
   wire [1:0] adv_w;

   wire setup_w = psel & ~penable;
   wire done_w = (st_r == ST_DONE) & psel & penable;
   wire ch_w = paddr[`HSI_CH_BIT];
   wire [2:0] idx_w = paddr[`HSI_IDX_HI:`HSI_IDX_LO];
   wire bad_addr_w = (paddr[`HSI_ADDR_W-1:`HSI_CH_BIT+1] != 2'h0) |
                     (paddr[`HSI_IDX_LO-1:0] != 2'h0);
   wire wr_w = done_w & pwrite & ~bad_addr_w;
   wire rd_done_w = done_w & ~pwrite & ~bad_addr_w;

   // Pointer bits in channel B's primary register.
   wire ica_w = |(prim_w[`HSI_PRIM_SRC_HI:`HSI_PRIM_SRC_LO] &
                  ~mask_w[`HSI_PRIM_SRC_HI:`HSI_PRIM_SRC_LO]); // R10 R23
   wire exa_w = |ext_w[7:0]; // R10
   wire exb_w = |ext_w[15:8]; // R10
   wire [7:0] prim_b_view_w = {prim_w[8+`HSI_PRIM_SRC_HI:8+`HSI_PRIM_SRC_LO],
                               ica_w, exa_w, exb_w}; // R10 R11
   wire [7:0] prim_a_view_w = {prim_w[`HSI_PRIM_SRC_HI:`HSI_PRIM_SRC_LO], 3'h0};
   // All channels funnel through channel B's view and its mask.
   wire irq_any_w = |(prim_b_view_w & ~mask_w[15:8]); // R8 R13 R14 R15 R23

   genvar c;
   generate
      for (c = 0; c < 2; c = c + 1) begin : g_ch
         reg [7:0] prim_r;
         reg [7:0] ext_r;
         reg [5:0] lvl_r;
         reg [1:0] bcnt_r;
         reg [7:0] pset;
         reg [7:0] eset;
         wire [7:0] pclr;
         wire [7:0] eclr;
         wire clean = ~rx_crc_err[c] & ~rx_aborted[c];
         wire info_end = rx_frame_done[c] & rx_frame_is_info[c];
         wire sup_end = rx_frame_done[c] & rx_frame_is_super[c];
         wire [5:0] lvl = rx_buf_count[6*c+5:6*c];
         wire pool_evt;
         wire end_evt;
         wire perr_evt;
         wire fs_evt;
         wire ovf_evt;
         wire sel = rd_done_w & (ch_w == c);

         // Pool full only on the rising crossing of a still open message.
         assign pool_evt = ~dma_w[c] & ~rx_msg_done[c] &
                           (lvl == `HSI_POOL_BYTES) & (lvl_r != `HSI_POOL_BYTES); // R16
         assign end_evt = (dma_w[c] ? rx_dma_read_done[c] : rx_msg_done[c]) | // R17 R18
                          (info_end & ~clean); // R1
         assign perr_evt = (info_end & clean & ~rx_ns_err[c] & rx_nr_err[c]) | // R1
                           (sup_end & clean & (rx_nr_err[c] | rx_has_ifield[c])); // R2
         assign ovf_evt = rx_frame_begin[c] & rx_buf_full[c]; // R19
         assign cap_w[c] = recog_w[c] ? rx_addr_match[c] : // R21
                           (rx_byte_strobe[c] & (bcnt_r == `HSI_FS_BYTE_IDX)); // R21
         assign fs_evt = cap_w[c] & fs_en_w[c]; // R20
         assign crc_set_w[c] = info_end & rx_crc_err[c]; // R1
         assign abort_set_w[c] = info_end & rx_aborted[c] & ~rx_crc_err[c]; // R1
         assign sresp_w[c] = info_end & clean & rx_ns_err[c]; // R1
         // Counters advance only on error-free frames.
         assign adv_w[c] = rx_frame_done[c] & clean & ~rx_ns_err[c] &
                           ~rx_nr_err[c] & ~(rx_frame_is_super[c] & rx_has_ifield[c]); // R3

         always @* begin
            pset = `HSI_RST_BYTE;
            pset[`HSI_PRIM_MSG_END] = end_evt; // R17 R18
            pset[`HSI_PRIM_POOL_FULL] = pool_evt; // R16
            eset = `HSI_RST_BYTE;
            eset[`HSI_EXT_PROTO_ERR] = perr_evt; // R1 R2
            eset[`HSI_EXT_FRAME_OVF] = ovf_evt; // R19
            eset[`HSI_EXT_FRAME_START] = fs_evt; // R20
         end
         assign pclr = (sel && idx_w == `HSI_REG_PRIM) ? snap_r : `HSI_RST_BYTE; // R13
         assign eclr = (sel && idx_w == `HSI_REG_EXT) ? snap_r : `HSI_RST_BYTE; // R13

         always @(posedge clk) begin
            if (rst) begin
               prim_r <= `HSI_RST_BYTE;
               ext_r <= `HSI_RST_BYTE;
               lvl_r <= 6'h00;
               bcnt_r <= 2'h0;
            end else begin
               prim_r <= hsi_upd(prim_r, pset, pclr); // R9
               ext_r <= hsi_upd(ext_r, eset, eclr); // R9
               lvl_r <= lvl;
               if (rx_frame_begin[c]) begin
                  bcnt_r <= 2'h0;
               end else if (rx_byte_strobe[c] && bcnt_r != `HSI_BCNT_MAX) begin
                  bcnt_r <= bcnt_r + 2'h1;
               end
            end
         end

         assign prim_w[8*c+7:8*c] = prim_r;
         assign ext_w[8*c+7:8*c] = ext_r;

         hsi_chan_regs u_regs (
            .clk(clk),
            .rst(rst),
            .wr_en(wr_w & (ch_w == c)), // R5
            .wr_idx(idx_w),
            .wr_data(pwdata[7:0]), // R4
            .rd_en(setup_w & (ch_w == c)),
            .rd_idx(idx_w),
            .rd_data_r(sub_rd_w[8*c+7:8*c]),
            .mask(mask_w[8*c+7:8*c]),
            .dma_sel(dma_w[c]), // R6 R7
            .fs_en(fs_en_w[c]),
            .addr_recog(recog_w[c]),
            .cap_en(cap_w[c]), // R22
            .cap_header(rx_header_in[8*c+7:8*c]),
            .cap_address(rx_address_in[8*c+7:8*c]),
            .cap_status(rx_status_in[4*c+3:4*c]),
            .crc_set(crc_set_w[c]),
            .abort_set(abort_set_w[c])
         );
      end
   endgenerate

   // Read mux for the fetch cycle; sub-module bytes were loaded at setup.
   always @* begin
      err_nxt = bad_addr_w;
      rd_nxt = `HSI_RST_BYTE;
      if (!bad_addr_w) begin
         case (idx_w)
            `HSI_REG_PRIM: rd_nxt = ch_w ? prim_b_view_w : prim_a_view_w; // R10 R11
            `HSI_REG_EXT: rd_nxt = ch_w ? ext_w[15:8] : ext_w[7:0];
            default: rd_nxt = ch_w ? sub_rd_w[15:8] : sub_rd_w[7:0];
         endcase
      end
   end

   // One wait state keeps prdata a flop without losing clear-on-read events.
   always @(posedge clk) begin
      if (rst) begin
         st_r <= ST_IDLE;
         snap_r <= `HSI_RST_BYTE;
         prdata <= `HSI_RST_WORD;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         case (st_r)
            ST_IDLE: begin
               pready <= 1'b0;
               pslverr <= 1'b0;
               if (setup_w) begin
                  st_r <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               prdata <= {24'h000000, rd_nxt}; // R4
               snap_r <= pwrite ? `HSI_RST_BYTE : rd_nxt;
               pslverr <= err_nxt;
               pready <= 1'b1;
               st_r <= ST_DONE;
            end
            ST_DONE: begin
               if (done_w) begin
                  pready <= 1'b0;
                  pslverr <= 1'b0;
                  st_r <= ST_IDLE;
               end
            end
            default: begin
               pready <= 1'b0;
               pslverr <= 1'b0;
               st_r <= ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         int_n <= 1'b1;
         s_response_req <= 2'h0;
         state_advance <= 2'h0;
         dma_mode <= 2'h0;
      end else begin
         int_n <= ~irq_any_w; // R8 R13 R14
         s_response_req <= sresp_w; // R1 R2
         state_advance <= adv_w; // R3
         dma_mode <= dma_w; // R6 R7
      end
   end

endmodule // hsi_rx_irq_status

`default_nettype wire

/* hsi_defines.vh */
// Constants shared by the receive error and interrupt status block.
`ifndef HSI_DEFINES_VH
`define HSI_DEFINES_VH

// Address decode: byte address bits and per-channel register indices.
`define HSI_ADDR_W 8
`define HSI_CH_BIT 5
`define HSI_IDX_HI 4
`define HSI_IDX_LO 2
`define HSI_REG_PRIM 3'h0
`define HSI_REG_EXT 3'h1
`define HSI_REG_MASK 3'h2
`define HSI_REG_TXBCH 3'h3
`define HSI_REG_CFG2 3'h4
`define HSI_REG_RX_HEADER_CONTROL_BYTE 3'h5
`define HSI_REG_RX_ADDRESS_LOW_ONE 3'h6
`define HSI_REG_RX_FRAME_STATUS 3'h7

// Primary status fields.
`define HSI_PRIM_MSG_END 7
`define HSI_PRIM_POOL_FULL 6
`define HSI_PRIM_SRC_HI 7
`define HSI_PRIM_SRC_LO 3
`define HSI_PRIM_ICA 2
`define HSI_PRIM_EXA 1
`define HSI_PRIM_EXB 0

// Extended status fields.
`define HSI_EXT_PROTO_ERR 5
`define HSI_EXT_FRAME_OVF 4
`define HSI_EXT_FRAME_START 2

// Control fields.
`define HSI_TXBCH_DMA 7
`define HSI_CFG2_FS_EN 3
`define HSI_CFG2_ADDR_RECOG 0
`define HSI_RX_FRAME_STATUS_CRC 5
`define HSI_RX_FRAME_STATUS_ABORT 4

// Reset values.
`define HSI_RST_BYTE 8'h00
`define HSI_RST_WORD 32'h00000000

// Receive buffer pool size and frame start byte position.
`define HSI_POOL_BYTES 6'h20
`define HSI_FS_BYTE_IDX 2'h1
`define HSI_BCNT_MAX 2'h3

`endif

/* hsi_chan_regs.v */
// One channel's control bytes and captured receive header bytes.
`include "hsi_defines.vh"
`default_nettype none

module hsi_chan_regs (
   input wire clk,
   input wire rst,
   input wire wr_en,
   input wire [2:0] wr_idx,
   input wire [7:0] wr_data,
   input wire rd_en,
   input wire [2:0] rd_idx,
   output reg [7:0] rd_data_r,
   output wire [7:0] mask,
   output wire dma_sel,
   output wire fs_en,
   output wire addr_recog,
   input wire cap_en,
   input wire [7:0] cap_header,
   input wire [7:0] cap_address,
   input wire [3:0] cap_status,
   input wire crc_set,
   input wire abort_set
);

   reg [7:0] mask_r;
   reg [7:0] tx_byte_count_high_r;
   reg [7:0] channel_config_two_r;
   reg [7:0] rx_header_control_byte_r;
   reg [7:0] rx_address_low_one_r;
   reg [7:0] rx_frame_status_r;
   reg [7:0] sta_nxt;

   assign mask = mask_r;
   assign dma_sel = tx_byte_count_high_r[`HSI_TXBCH_DMA];
   assign fs_en = channel_config_two_r[`HSI_CFG2_FS_EN];
   assign addr_recog = channel_config_two_r[`HSI_CFG2_ADDR_RECOG];

   always @* begin
      sta_nxt = cap_en ? {4'h0, cap_status} : rx_frame_status_r; // R22
      sta_nxt[`HSI_RX_FRAME_STATUS_CRC] = sta_nxt[`HSI_RX_FRAME_STATUS_CRC] | crc_set; // R1
      sta_nxt[`HSI_RX_FRAME_STATUS_ABORT] = sta_nxt[`HSI_RX_FRAME_STATUS_ABORT] | abort_set; // R1
   end

   always @(posedge clk) begin
      if (rst) begin
         mask_r <= `HSI_RST_BYTE;
         tx_byte_count_high_r <= `HSI_RST_BYTE; // R6
         channel_config_two_r <= `HSI_RST_BYTE;
         rx_header_control_byte_r <= `HSI_RST_BYTE;
         rx_address_low_one_r <= `HSI_RST_BYTE;
         rx_frame_status_r <= `HSI_RST_BYTE;
         rd_data_r <= `HSI_RST_BYTE;
      end else begin
         if (wr_en && wr_idx == `HSI_REG_MASK) begin
            mask_r <= wr_data; // R14 R15
         end
         if (wr_en && wr_idx == `HSI_REG_TXBCH) begin
            tx_byte_count_high_r <= wr_data; // R6 R7
         end
         if (wr_en && wr_idx == `HSI_REG_CFG2) begin
            channel_config_two_r <= wr_data;
         end
         if (cap_en) begin
            rx_header_control_byte_r <= cap_header; // R22
            rx_address_low_one_r <= cap_address; // R22
         end
         rx_frame_status_r <= sta_nxt;
         if (rd_en) begin
            case (rd_idx)
               `HSI_REG_MASK: rd_data_r <= mask_r;
               `HSI_REG_TXBCH: rd_data_r <= tx_byte_count_high_r;
               `HSI_REG_CFG2: rd_data_r <= channel_config_two_r;
               `HSI_REG_RX_HEADER_CONTROL_BYTE: rd_data_r <= rx_header_control_byte_r;
               `HSI_REG_RX_ADDRESS_LOW_ONE: rd_data_r <= rx_address_low_one_r;
               `HSI_REG_RX_FRAME_STATUS: rd_data_r <= rx_frame_status_r;
               default: rd_data_r <= `HSI_RST_BYTE;
            endcase
         end
      end
   end

endmodule // hsi_chan_regs

`default_nettype wire

/* hsi_rx_irq_status_monitor.sv */
// Port checks for the receive status and interrupt block.
`include "hsi_defines.vh"
`default_nettype none
module hsi_rx_irq_status_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [`HSI_ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] rx_frame_done,
   input wire logic [1:0] rx_frame_is_info,
   input wire logic [1:0] rx_crc_err,
   input wire logic [1:0] rx_aborted,
   input wire logic [1:0] rx_ns_err,
   input wire logic [1:0] rx_nr_err,
   input wire logic [1:0] s_response_req,
   input wire logic [1:0] state_advance,
   input wire logic [1:0] dma_mode
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   ans_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("Ready did not come two cycles after setup.");
   ans_once_a: assert property (pready |=> !pready)
      else $error("Ready stood longer than one cycle.");
   err_bad_a: assert property (pready && (paddr[1:0] != 2'h0 || paddr[7:6] != 2'h0)
      |-> pslverr)
      else $error("Unmapped access was not refused.");
   err_quiet_a: assert property (pslverr |-> pready &&
      (paddr[1:0] != 2'h0 || paddr[7:6] != 2'h0))
      else $error("Error raised on a mapped access.");
   rd_upper_a: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("Read data wider than a byte.");
   resp_send_a: assert property (rx_frame_done[0] && rx_frame_is_info[0] && rx_ns_err[0]
      && !rx_crc_err[0] && !rx_aborted[0] |=> s_response_req[0])
      else $error("No response for an out of sequence frame.");
   resp_cause_a: assert property (s_response_req[0] |->
      $past(rx_frame_done[0] && rx_frame_is_info[0] && rx_ns_err[0]))
      else $error("Response without a sequence error.");
   no_advance_a: assert property (rx_frame_done[0] && (rx_crc_err[0] || rx_aborted[0]
      || rx_ns_err[0] || rx_nr_err[0]) |=> !state_advance[0])
      else $error("State advanced on a bad frame.");
   dma_reset_a: assert property ($past(rst) |-> dma_mode == 2'b00)
      else $error("Transfer mode not interrupt after reset.");
endmodule // hsi_rx_irq_status_monitor
bind hsi_rx_irq_status hsi_rx_irq_status_monitor u_mon (.*);
`default_nettype wire

/* hsi_rx_src.sv */
// Receive front end model that feeds frame events into the status block.
`default_nettype none
module hsi_rx_src (
   input wire logic clk,
   output logic [1:0] rx_frame_begin,
   output logic [1:0] rx_byte_strobe,
   output logic [11:0] rx_buf_count,
   output logic [1:0] rx_buf_full,
   output logic [1:0] rx_msg_done,
   output logic [1:0] rx_dma_read_done,
   output logic [1:0] rx_frame_done,
   output logic [1:0] rx_frame_is_info,
   output logic [1:0] rx_frame_is_super,
   output logic [1:0] rx_crc_err,
   output logic [1:0] rx_aborted,
   output logic [1:0] rx_ns_err,
   output logic [1:0] rx_nr_err,
   output logic [1:0] rx_has_ifield
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {rx_frame_begin, rx_byte_strobe, rx_buf_full, rx_msg_done, rx_dma_read_done} = 10'h000;
      rx_buf_count = 12'h000;
      {rx_frame_done, rx_frame_is_info, rx_frame_is_super, rx_crc_err} = 8'h00;
      {rx_aborted, rx_ns_err, rx_nr_err, rx_has_ifield} = 8'h00;
   end
   // Kinds: 0 frame begin, 1 byte, 2 message done, 3 read-out done.
   task ev(input int k, input int ch);
      @(posedge clk);
      case (k)
         0: rx_frame_begin <= 2'(1 << ch);
         1: rx_byte_strobe <= 2'(1 << ch);
         2: rx_msg_done <= 2'(1 << ch);
         default: rx_dma_read_done <= 2'(1 << ch);
      endcase
      @(posedge clk);
      {rx_frame_begin, rx_byte_strobe, rx_msg_done, rx_dma_read_done} <= 8'h00;
   endtask
   task frm(input int ch, input logic [6:0] f);
      logic [1:0] b;
      b = 2'(1 << ch);
      @(posedge clk);
      rx_frame_done <= b;
      rx_frame_is_info <= f[6] ? b : 2'h0;
      rx_frame_is_super <= f[5] ? b : 2'h0;
      rx_crc_err <= f[4] ? b : 2'h0;
      rx_aborted <= f[3] ? b : 2'h0;
      rx_ns_err <= f[2] ? b : 2'h0;
      rx_nr_err <= f[1] ? b : 2'h0;
      rx_has_ifield <= f[0] ? b : 2'h0;
      @(posedge clk);
      rx_frame_done <= 2'h0;
      // Qualifiers mean nothing outside the done pulse, so they are scrambled.
      {rx_frame_is_info, rx_frame_is_super, rx_crc_err, rx_aborted} <=
         ~{rx_frame_is_info, rx_frame_is_super, rx_crc_err, rx_aborted};
      {rx_ns_err, rx_nr_err, rx_has_ifield} <= ~{rx_ns_err, rx_nr_err, rx_has_ifield};
   endtask
   task lvl(input int ch, input int n, input logic fl);
      @(posedge clk);
      rx_buf_count[ch * 6 +: 6] <= 6'(n);
      rx_buf_full[ch] <= fl;
      @(posedge clk);
   endtask
endmodule // hsi_rx_src
`default_nettype wire

/* hsi_rx_irq_status_tb.sv */
// Self-checking bench for the receive status and interrupt block.
`default_nettype none
module hsi_rx_irq_status_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, int_n;
   logic [1:0] rx_frame_begin, rx_byte_strobe, rx_buf_full, rx_msg_done, rx_dma_read_done;
   logic [1:0] rx_frame_done, rx_frame_is_info, rx_frame_is_super, rx_crc_err, rx_aborted;
   logic [1:0] rx_ns_err, rx_nr_err, rx_has_ifield, s_response_req, state_advance, dma_mode;
   logic [1:0] rx_addr_match = 2'h0;
   logic [11:0] rx_buf_count;
   logic [15:0] rx_header_in = 16'h0000, rx_address_in = 16'h0000;
   logic [7:0] rx_status_in = 8'h00;
   int st[4] = '{0, 0, 0, 0};
   int msk[2] = '{0, 0};
   int miscompares = 0, checks = 0, cyc = 0;
   hsi_rx_irq_status u_hsi_rx_irq_status (.*);
   hsi_rx_src src (.*);
   always #4 clk = ~clk;
   task test_done;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         test_done;
      end
   end
   task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d,
            output logic [31:0] r, output logic er);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic er;
      apb(1'b1, a, d, r, er);
      cmp("wr_err", 1'b0, er);
      if (a[4:2] == 3'h2) msk[a[5]] = d;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] r;
      logic er;
      apb(1'b0, a, 8'h00, r, er);
      cmp("rdata", {24'h000000, e}, r);
      cmp("rd_err", 1'b0, er);
   endtask
   // Channel B primary view: own sources plus three derived pointers.
   function automatic int bview();
      int p;
      p = st[2] & 8'hF8;
      if ((st[0] & ~msk[0] & 8'hF8) != 0) p |= 4;
      if (st[1] != 0) p |= 2;
      if (st[3] != 0) p |= 1;
      return p;
   endfunction
   task rs(input int ch, input int x);
      rd(8'(ch * 32 + x * 4), 8'((ch == 1 && x == 0) ? bview() : st[ch * 2 + x]));
      st[ch * 2 + x] = 0;
   endtask
   task chi;
      repeat (2) @(posedge clk);
      cmp("int_n", {31'h0, (bview() & ~msk[1] & 255) == 0}, int_n);
   endtask
   initial begin
      logic [31:0] r;
      logic er;
      logic [7:0] rv[6];
      logic [6:0] f;
      logic [6:0] fc[9];
      int rsv;
      fc = '{7'h50, 7'h48, 7'h44, 7'h42, 7'h30, 7'h28, 7'h22, 7'h21, 7'h40};
      void'($urandom(32'hD596));
      @(posedge clk);
      rx_header_in <= 16'($urandom);
      rx_address_in <= 16'($urandom);
      rx_status_in <= 8'($urandom);
      @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 16; i++) rd(8'(i * 4), 8'h00);
      cmp("dma_mode", 2'b00, dma_mode);
      cmp("int_n", 1'b1, int_n);
      apb(1'b0, 8'h40, 8'h00, r, er);
      cmp("bad_rd", 1'b1, er);
      apb(1'b1, 8'h06, 8'hFF, r, er);
      cmp("bad_wr", 1'b1, er);
      for (int i = 0; i < 6; i++) begin
         rv[i] = 8'($urandom);
         wr(8'((i / 3) * 32 + (i % 3 + 2) * 4), rv[i]);
      end
      for (int i = 0; i < 6; i++) rd(8'((i / 3) * 32 + (i % 3 + 2) * 4), rv[i]);
      wr(8'h0C, 8'h80);
      wr(8'h2C, 8'h00);
      repeat (2) @(posedge clk);
      cmp("dma_mode", 2'b01, dma_mode);
      wr(8'h0C, 8'h00);
      wr(8'h08, 8'h00);
      wr(8'h28, 8'h00);
      wr(8'h10, 8'h08);
      wr(8'h30, 8'h00);
      src.ev(2, 1);
      st[2] |= 8'h80;
      chi;
      rs(1, 0);
      chi;
      src.ev(2, 1);
      st[2] |= 8'h80;
      wr(8'h28, 8'hFF);
      chi;
      wr(8'h28, 8'h00);
      chi;
      rs(1, 0);
      wr(8'h08, 8'h80);
      src.ev(2, 0);
      st[0] |= 8'h80;
      chi;
      rs(0, 0);
      wr(8'h08, 8'h00);
      src.lvl(0, 32, 1'b0);
      st[0] |= 8'h40;
      chi;
      rs(1, 0);
      rs(0, 0);
      src.lvl(0, 0, 1'b0);
      wr(8'h0C, 8'h80);
      src.lvl(0, 32, 1'b0);
      src.ev(2, 0);
      chi;
      src.ev(3, 0);
      st[0] |= 8'h80;
      rs(0, 0);
      wr(8'h0C, 8'h00);
      src.lvl(0, 0, 1'b0);
      src.lvl(1, 0, 1'b1);
      src.ev(0, 1);
      st[3] |= 8'h10;
      src.lvl(1, 0, 1'b0);
      src.ev(1, 1);
      src.ev(1, 1);
      rs(1, 0);
      rs(1, 1);
      src.ev(0, 0);
      src.ev(1, 0);
      rs(0, 1);
      src.ev(1, 0);
      st[1] |= 8'h04;
      rs(0, 1);
      rd(8'h14, rx_header_in[7:0]);
      rd(8'h18, rx_address_in[7:0]);
      rd(8'h1C, {4'h0, rx_status_in[3:0]});
      rsv = rx_status_in[3:0];
      foreach (fc[i]) begin
         f = fc[i];
         src.frm(0, f);
         @(negedge clk);
         cmp("resp", {1'b0, f[6] && f[2] && !f[4] && !f[3]}, s_response_req);
         cmp("advance", {1'b0, f[4:0] == 5'h00}, state_advance);
         if (f[6] && (f[4] || f[3])) st[0] |= 8'h80;
         if ((f[1] || f[5] && f[0]) && !f[4] && !f[3]) st[1] |= 8'h20;
         rsv |= f[6] ? (f[4] ? 8'h20 : (f[3] ? 8'h10 : 8'h00)) : 8'h00;
         rs(0, 0);
         rs(0, 1);
         rd(8'h1C, 8'(rsv));
      end
      // Address recognition path: the match pulse, not the byte count, starts the frame.
      wr(8'h10, 8'h09);
      @(posedge clk);
      rx_header_in <= 16'($urandom);
      rx_addr_match <= 2'b01;
      @(posedge clk);
      rx_addr_match <= 2'b00;
      st[1] |= 8'h04;
      rs(0, 1);
      rd(8'h14, rx_header_in[7:0]);
      rd(8'h1C, {4'h0, rx_status_in[3:0]});
      test_done;
   end
endmodule // hsi_rx_irq_status_tb
`default_nettype wire
